// ### common/asx_pkg.sv
//==========================================================
// Notes on behaviour
// - ext bit 7 zero inhibits rx-full interrupt; one releases it; resets 0
// - ch0 ext bit 6 zero lets carrier detect gate receive status
// - ch0 ext bit 5 zero lets clear-to-send gate transmit status
// - ch0 clear-to-send high holds tx-empty flag at zero
// - clear-to-send masks only the flag; shifting continues
// - carrier detect high holds rx-full flag at zero
// - carrier detect high also zeroes parity, framing and overrun flags
// - after carrier drops, flags stay held until ch0 status read
// - first status read after carrier drop still shows carrier bit as one
// - request-to-send is a plain 1-bit output with no side effects
// - ch1 clear-to-send gates tx-empty only when select bit is one
// - bit 3 enables 16-bit rate counter; bit 4 makes clock pin bit clock
// - bit 2 zero enables break detection; bit 1 break detect; bit 0 sends break
// - ch1 ext at 13H, bits 6-5 reserved zero, resets zero
// - time constants at 1AH-1DH, 8-bit read/write, reset zero
package asx_pkg;
    localparam logic [7:0] ASX_A_EXT0 = 8'h12;
    localparam logic [7:0] ASX_A_EXT1 = 8'h13;
    localparam logic [7:0] ASX_A_TCL0 = 8'h1A;
    localparam logic [7:0] ASX_A_TCH0 = 8'h1B;
    localparam logic [7:0] ASX_A_TCL1 = 8'h1C;
    localparam logic [7:0] ASX_A_TCH1 = 8'h1D;
    localparam logic [7:0] ASX_EXT_RST = 8'h00;
    localparam logic [7:0] ASX_TC_RST = 8'h00;
    localparam logic [7:0] ASX_EXT1_WMASK = 8'h9D;
    localparam logic [7:0] ASX_EXT0_WMASK = 8'hFD;
    localparam int ASX_B_RXIE = 7;
    localparam int ASX_B_DCDDIS = 6;
    localparam int ASX_B_CTSDIS = 5;
    localparam int ASX_B_X1 = 4;
    localparam int ASX_B_RATE = 3;
    localparam int ASX_B_BRKEN = 2;
    localparam int ASX_B_BRKDET = 1;
    localparam int ASX_B_SNDBRK = 0;
    localparam int ASX_TX_FIFO_DEPTH = 2;

    typedef struct packed {
        logic rx_full;
        logic tx_empty;
        logic parity_err;
        logic framing_err;
        logic overrun;
    } asx_flags_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } asx_bus_t;
endpackage : asx_pkg

// ### hdl/asx_rate_gen.sv
`timescale 1ns/10ps
//==========================================================
// 16-bit reload down-counter, one tick per terminal count
module asx_rate_gen #(
    parameter int WIDTH = 16
) (
    input wire logic clk,              // system clock
    input wire logic rst_b,            // async reset, low
    input wire logic enable,           // rate mode on
    input wire logic [WIDTH-1:0] reload, // high:low constant
    output logic tick                  // one-cycle sample tick
);
    import asx_pkg::*;
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic tick_r;
    wire term = (cnt_r == '0);

    assign cnt_nxt = !enable ? reload : (term ? reload : cnt_r - 1'b1);
    assign tick = tick_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= enable & term;
        end
    end
endmodule : asx_rate_gen

// ### hdl/asx_skid.sv
`timescale 1ns/10ps
//==========================================================
// two-entry buffer with valid/ready each side
module asx_skid #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,              // system clock
    input wire logic rst_b,            // async reset, low
    input wire logic in_valid,         // word offered
    output logic in_ready,             // room left
    input wire logic [WIDTH-1:0] in_data, // word in
    output logic out_valid,            // word held
    input wire logic out_ready,        // taker ready
    output logic [WIDTH-1:0] out_data  // oldest word
);
    import asx_pkg::*;
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
        end else begin
            if (push) begin
                mem_r[wp_r] <= in_data;
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : asx_skid

// ### hdl/asx_ext_top.sv
`timescale 1ns/10ps
//==========================================================
// serial channel extension and modem handshake logic
module asx_ext_top (
    input wire logic MCLK,                  // 250 MHz system clock
    input wire logic RST_B,                 // async reset, low
    input wire asx_pkg::asx_bus_t IO_BUS,   // I/O write/read strobe
    output logic [7:0] IO_RDATA,            // read data, registered
    output logic IO_HIT,                    // address decoded here
    input wire asx_pkg::asx_flags_t CH0_RAW,// ch0 core raw flags
    input wire asx_pkg::asx_flags_t CH1_RAW,// ch1 core raw flags
    output asx_pkg::asx_flags_t CH0_FLAGS,  // ch0 gated flags
    output asx_pkg::asx_flags_t CH1_FLAGS,  // ch1 gated flags
    input wire logic CH0_STAT_RD,           // ch0 status read strobe
    output logic CH0_DCD_STAT,              // carrier bit for status
    output logic CH0_CTS_STAT,              // cts bit for status
    output logic CH1_CTS_STAT,              // ch1 cts bit for status
    input wire logic CH1_CTS_SEL,           // ch1 cts select bit
    input wire logic CARRIER_DETECT_IN,     // ch0 carrier pin
    input wire logic CLEAR_TO_SEND_IN,      // ch0 cts pin
    input wire logic CLOCKED_SERIAL_RX_DATA,// shared ch1 cts pin
    input wire logic RTS_WR,                // rts port write strobe
    input wire logic RTS_WDATA,             // rts value
    output logic REQUEST_TO_SEND_OUT,       // rts pin
    input wire logic [1:0] RX_LINE,         // receive lines, per ch
    input wire logic [1:0] CORE_TX_LINE,    // core tx bits, per ch
    output logic [1:0] TX_LINE,             // tx pins, per ch
    output logic [1:0] RX_INT_EN,           // rx-full interrupt gate
    output logic [1:0] X1_CLK_MODE,         // ext clock is bit clock
    output logic [1:0] RATE_MODE,           // 16-bit rate mode
    output logic [1:0] RATE_TICK,           // rate generator tick
    input wire logic [1:0] TXD_VALID,       // tx word offered
    output logic [1:0] TXD_READY,           // tx buffer room
    input wire logic [15:0] TXD_DATA,       // tx words, ch1:ch0
    output logic [1:0] SHF_VALID,           // word for shifter
    input wire logic [1:0] SHF_READY,       // shifter takes word
    output logic [15:0] SHF_DATA            // words, ch1:ch0
);
    import asx_pkg::*;

    //==========================================================
    // pin synchronisers
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [1:0] rxl_meta_r;
    logic [1:0] rxl_sync_r;
    wire dcd_s = sync_r[0];
    wire clear_to_send_in_s = sync_r[1];
    wire ch1_clear_to_send_in_s = sync_r[2];

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
            rxl_meta_r <= 2'h3;
            rxl_sync_r <= 2'h3;
        end else begin
            meta_r <= {CLOCKED_SERIAL_RX_DATA, CLEAR_TO_SEND_IN,
                       CARRIER_DETECT_IN};
            sync_r <= meta_r;
            rxl_meta_r <= RX_LINE;
            rxl_sync_r <= rxl_meta_r;
        end
    end

    //==========================================================
    // register file
    logic [7:0] ext_r [2];
    logic [7:0] tcl_r [2];
    logic [7:0] tch_r [2];
    logic [1:0] brk_det_r;
    logic [7:0] rdata_nxt;

    wire wr = IO_BUS.wr;
    wire [7:0] a = IO_BUS.addr;
    wire hit_e0 = (a == ASX_A_EXT0);
    wire hit_e1 = (a == ASX_A_EXT1);
    wire hit_l0 = (a == ASX_A_TCL0);
    wire hit_h0 = (a == ASX_A_TCH0);
    wire hit_l1 = (a == ASX_A_TCL1);
    wire hit_h1 = (a == ASX_A_TCH1);
    wire [1:0] hit_ext = {hit_e1, hit_e0};
    wire [1:0] hit_tcl = {hit_l1, hit_l0};
    wire [1:0] hit_tch = {hit_h1, hit_h0};
    wire [7:0] wmask [2] = '{ASX_EXT0_WMASK, ASX_EXT1_WMASK};

    assign IO_HIT = |{hit_ext, hit_tcl, hit_tch};

    function automatic logic [7:0] ext_view(input logic [7:0] v,
                                            input logic det);
        logic [7:0] r;
        r = v;
        r[ASX_B_BRKDET] = det;
        return r;
    endfunction : ext_view

    assign rdata_nxt = hit_e0 ? ext_view(ext_r[0], brk_det_r[0]) :
                       hit_e1 ? ext_view(ext_r[1], brk_det_r[1]) :
                       hit_l0 ? tcl_r[0] :
                       hit_h0 ? tch_r[0] :
                       hit_l1 ? tcl_r[1] :
                       hit_h1 ? tch_r[1] : 8'h00;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) IO_RDATA <= 8'h00;
        else if (IO_BUS.rd) IO_RDATA <= rdata_nxt;
    end

    //==========================================================
    // per-channel extension logic
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            wire [7:0] wv = IO_BUS.wdata & wmask[c];
            wire rx_idle = rxl_sync_r[c];
            logic [7:0] low_cnt_r;
            logic [7:0] low_cnt_nxt;

            always_ff @(posedge MCLK or negedge RST_B) begin
                if (!RST_B) begin
                    ext_r[c] <= ASX_EXT_RST;
                    tcl_r[c] <= ASX_TC_RST;
                    tch_r[c] <= ASX_TC_RST;
                end else begin
                    // bits 6-5 of ch1 and break detect masked off
                    if (wr && hit_ext[c]) ext_r[c] <= wv;
                    if (wr && hit_tcl[c]) tcl_r[c] <= IO_BUS.wdata;
                    if (wr && hit_tch[c]) tch_r[c] <= IO_BUS.wdata;
                end
            end

            // break detect: line low for 255 system clocks in a row
            assign low_cnt_nxt = rx_idle ? 8'h00 :
                                 (low_cnt_r == 8'hFF) ? low_cnt_r :
                                 low_cnt_r + 8'h01;
            always_ff @(posedge MCLK or negedge RST_B) begin
                if (!RST_B) begin
                    low_cnt_r <= 8'h00;
                    brk_det_r[c] <= 1'b0;
                end else begin
                    low_cnt_r <= low_cnt_nxt;
                    // feature enabled when bit 2 is zero
                    brk_det_r[c] <= !ext_r[c][ASX_B_BRKEN] &&
                                    (low_cnt_r == 8'hFF);
                end
            end

            assign RX_INT_EN[c] = ext_r[c][ASX_B_RXIE];
            assign X1_CLK_MODE[c] = ext_r[c][ASX_B_X1];
            assign RATE_MODE[c] = ext_r[c][ASX_B_RATE];
            assign TX_LINE[c] = ext_r[c][ASX_B_SNDBRK] ? 1'b0 :
                                CORE_TX_LINE[c];

            asx_rate_gen #(.WIDTH(16)) u_rate (
                .clk(MCLK),
                .rst_b(RST_B),
                .enable(ext_r[c][ASX_B_RATE]),
                .reload({tch_r[c], tcl_r[c]}),
                .tick(RATE_TICK[c])
            );

            asx_skid #(.WIDTH(8), .DEPTH(ASX_TX_FIFO_DEPTH)) u_buf (
                .clk(MCLK),
                .rst_b(RST_B),
                .in_valid(TXD_VALID[c]),
                .in_ready(TXD_READY[c]),
                .in_data(TXD_DATA[c*8 +: 8]),
                .out_valid(SHF_VALID[c]),
                .out_ready(SHF_READY[c]),
                .out_data(SHF_DATA[c*8 +: 8])
            );
        end
    endgenerate

    //==========================================================
    // channel 0 carrier hold and status latch
    logic dcd_hold_r;
    logic dcd_stat_r;
    wire dcd_gate_en = !ext_r[0][ASX_B_DCDDIS];
    wire clear_to_send_in_gate_en = !ext_r[0][ASX_B_CTSDIS];

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            dcd_hold_r <= 1'b0;
            dcd_stat_r <= 1'b0;
        end else begin
            // carrier high sets the status bit, and the hold when gating is on; either wins over a coincident read
            if (dcd_s && dcd_gate_en) dcd_hold_r <= 1'b1;
            else if (CH0_STAT_RD) dcd_hold_r <= 1'b0;
            if (dcd_s) dcd_stat_r <= 1'b1;
            else if (CH0_STAT_RD) dcd_stat_r <= 1'b0;
        end
    end

    wire rx_block = dcd_hold_r || (dcd_s && dcd_gate_en);
    wire tx_block0 = clear_to_send_in_s && clear_to_send_in_gate_en;
    wire tx_block1 = ch1_clear_to_send_in_s && CH1_CTS_SEL;

    //==========================================================
    // gated flag outputs
    always_comb begin
        CH0_FLAGS = CH0_RAW;
        if (rx_block) begin
            CH0_FLAGS.rx_full = 1'b0;
            CH0_FLAGS.parity_err = 1'b0;
            CH0_FLAGS.framing_err = 1'b0;
            CH0_FLAGS.overrun = 1'b0;
        end
        // only the flag is masked; shifter keeps running
        if (tx_block0) CH0_FLAGS.tx_empty = 1'b0;
        CH1_FLAGS = CH1_RAW;
        if (tx_block1) CH1_FLAGS.tx_empty = 1'b0;
    end

    assign CH0_DCD_STAT = dcd_stat_r;
    assign CH0_CTS_STAT = clear_to_send_in_s;
    assign CH1_CTS_STAT = CH1_CTS_SEL & ch1_clear_to_send_in_s;

    //==========================================================
    // request-to-send port, touches nothing else
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) REQUEST_TO_SEND_OUT <= 1'b0;
        else if (RTS_WR) REQUEST_TO_SEND_OUT <= RTS_WDATA;
    end
endmodule : asx_ext_top

// ### tb/asx_chk.sv
`timescale 1ns/10ps
//==========================================================
// port-level checks for the extension block
module asx_chk (
    input wire logic MCLK,                  // clock
    input wire logic RST_B,                 // reset, low
    input wire asx_pkg::asx_bus_t IO_BUS,   // bus strobes
    input wire logic [7:0] IO_RDATA,        // read data
    input wire logic IO_HIT,                // decode
    input wire asx_pkg::asx_flags_t CH0_RAW,// raw flags
    input wire asx_pkg::asx_flags_t CH0_FLAGS,  // gated flags
    input wire asx_pkg::asx_flags_t CH1_FLAGS,  // gated flags
    input wire logic CH0_STAT_RD,           // status read
    input wire logic CH0_DCD_STAT,          // carrier bit
    input wire logic CH1_CTS_STAT,          // ch1 cts bit
    input wire logic CH1_CTS_SEL,           // ch1 select
    input wire logic RTS_WR,                // rts write
    input wire logic RTS_WDATA,             // rts value
    input wire logic REQUEST_TO_SEND_OUT,   // rts pin
    input wire logic [1:0] RATE_MODE,       // rate mode
    input wire logic [1:0] RATE_TICK,       // rate tick
    input wire logic [1:0] TXD_VALID,       // word offered
    input wire logic [1:0] TXD_READY,       // room
    input wire logic [1:0] SHF_VALID,       // word held
    input wire logic [1:0] SHF_READY,       // taker ready
    input wire logic [15:0] SHF_DATA        // words
);
    import asx_pkg::*;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    //==========================================================
    // sequences and properties
    sequence s_hold; CH0_DCD_STAT && !CH0_STAT_RD; endsequence
    sequence s_off2; !RATE_MODE[0] [*2]; endsequence
    sequence s_stall; SHF_VALID[1] && !SHF_READY[1]; endsequence
    property p_gate; (CH0_FLAGS & ~CH0_RAW) == 5'h00; endproperty
    property p_dcd; s_hold |=> CH0_DCD_STAT; endproperty
    property p_ch1_clear_to_send_in; CH1_CTS_STAT |-> !CH1_FLAGS.tx_empty; endproperty
    property p_sel1; !CH1_CTS_SEL |-> !CH1_CTS_STAT; endproperty
    property p_rtsw; RTS_WR |=> REQUEST_TO_SEND_OUT == $past(RTS_WDATA);
    endproperty
    property p_rtsh; !RTS_WR |=> $stable(REQUEST_TO_SEND_OUT); endproperty
    property p_rate; s_off2 |-> !RATE_TICK[0]; endproperty
    property p_rd; !IO_BUS.rd |=> $stable(IO_RDATA); endproperty
    property p_hit;
        IO_HIT == (IO_BUS.addr inside {8'h12, 8'h13, [8'h1A:8'h1D]});
    endproperty
    property p_buf;
        TXD_VALID[0] && TXD_READY[0] && !SHF_VALID[0] |=> SHF_VALID[0];
    endproperty
    property p_hold; s_stall |=> SHF_VALID[1] && $stable(SHF_DATA[15:8]);
    endproperty
    //==========================================================
    // assertions
    a_gate: assert property (p_gate) else $error("flag set");
    a_dcd: assert property (p_dcd) else $error("dcd bit lost");
    a_ch1_clear_to_send_in: assert property (p_ch1_clear_to_send_in) else $error("ch1 tx empty");
    a_sel1: assert property (p_sel1) else $error("ch1 cts on");
    a_rtsw: assert property (p_rtsw) else $error("rts value");
    a_rtsh: assert property (p_rtsh) else $error("rts moved");
    a_rate: assert property (p_rate) else $error("tick off");
    a_rd: assert property (p_rd) else $error("rdata moved");
    a_hit: assert property (p_hit) else $error("decode");
    a_buf: assert property (p_buf) else $error("word lost");
    a_hold: assert property (p_hold) else $error("stall lost");
endmodule : asx_chk

bind asx_ext_top asx_chk u_chk (.MCLK, .RST_B, .IO_BUS, .IO_RDATA,
    .IO_HIT, .CH0_RAW, .CH0_FLAGS, .CH1_FLAGS, .CH0_STAT_RD,
    .CH0_DCD_STAT, .CH1_CTS_STAT, .CH1_CTS_SEL, .RTS_WR, .RTS_WDATA,
    .REQUEST_TO_SEND_OUT, .RATE_MODE, .RATE_TICK, .TXD_VALID,
    .TXD_READY, .SHF_VALID, .SHF_READY, .SHF_DATA);

// ### tb/asx_modem.sv
`timescale 1ns/10ps
//==========================================================
// remote modem: handshake pins follow requests after a lag
module asx_modem #(
    parameter int LAG = 3
) (
    input wire logic clk,       // system clock
    input wire logic carrier,   // raise carrier
    input wire logic hold_tx,   // pause ch0 sender
    input wire logic hold_tx1,  // pause ch1 sender
    input wire logic brk,       // hold receive lines low
    output logic dcd_pin,       // carrier pin
    output logic cts_pin,       // ch0 clear-to-send pin
    output logic rxs_pin,       // shared ch1 pin
    output logic [1:0] rx_pin   // receive lines
);
    logic [2:0] dcd_r = '0;
    logic [2:0] cts_r = '0;
    logic [2:0] ch1_clear_to_send_in_r = '0;
    always @(posedge clk) begin
        dcd_r <= {dcd_r[1:0], carrier};
        cts_r <= {cts_r[1:0], hold_tx};
        ch1_clear_to_send_in_r <= {ch1_clear_to_send_in_r[1:0], hold_tx1};
    end
    assign dcd_pin = dcd_r[LAG-1];
    assign cts_pin = cts_r[LAG-1];
    assign rxs_pin = ch1_clear_to_send_in_r[LAG-1];
    // idle marks, spaces while a break is sent
    assign rx_pin = brk ? 2'h0 : 2'h3;
endmodule : asx_modem

// ### tb/test_asx_ext_top.sv
`timescale 1ns/10ps
//==========================================================
// directed bench for the extension block
module test_asx_ext_top;
    import asx_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    asx_bus_t bus = '0;
    asx_flags_t raw0 = '1;
    asx_flags_t raw1 = '1;
    asx_flags_t fl0, fl1;
    logic stat_rd = 1'b0, sel1 = 1'b0, rts_wr = 1'b0, rts_d = 1'b0;
    logic car = 1'b0, cts = 1'b0, ch1_clear_to_send_in = 1'b0, brk = 1'b0;
    logic [1:0] core_tx = 2'h3, txd_v = 2'h0, shf_r = 2'h0;
    logic [15:0] txd_d = 16'h0000;
    logic [15:0] shf_d;
    logic [7:0] rdata;
    logic dcd_s, cts_s, ch1_clear_to_send_in_s, rts, dcd_p, cts_p, rxs_p;
    logic [1:0] rxl, txl, rie, x1, rate, tick, txd_r, shf_v;
    logic [7:0] adr [6] = '{8'h12, 8'h13, 8'h1A, 8'h1B, 8'h1C, 8'h1D};
    int n_mismatch = 0;
    int comparisons = 0;
    int k, n;
    always #2 mclk = ~mclk;
    asx_modem #(.LAG(3)) u_modem (.clk(mclk), .carrier(car),
        .hold_tx(cts), .hold_tx1(ch1_clear_to_send_in), .brk(brk), .dcd_pin(dcd_p),
        .cts_pin(cts_p), .rxs_pin(rxs_p), .rx_pin(rxl));
    asx_ext_top dut (.MCLK(mclk), .RST_B(rst_b), .IO_BUS(bus),
        .IO_RDATA(rdata), .IO_HIT(), .CH0_RAW(raw0), .CH1_RAW(raw1),
        .CH0_FLAGS(fl0), .CH1_FLAGS(fl1), .CH0_STAT_RD(stat_rd),
        .CH0_DCD_STAT(dcd_s), .CH0_CTS_STAT(cts_s),
        .CH1_CTS_STAT(ch1_clear_to_send_in_s), .CH1_CTS_SEL(sel1),
        .CARRIER_DETECT_IN(dcd_p), .CLEAR_TO_SEND_IN(cts_p),
        .CLOCKED_SERIAL_RX_DATA(rxs_p), .RTS_WR(rts_wr),
        .RTS_WDATA(rts_d), .REQUEST_TO_SEND_OUT(rts), .RX_LINE(rxl),
        .CORE_TX_LINE(core_tx), .TX_LINE(txl), .RX_INT_EN(rie),
        .X1_CLK_MODE(x1), .RATE_MODE(rate), .RATE_TICK(tick),
        .TXD_VALID(txd_v), .TXD_READY(txd_r), .TXD_DATA(txd_d),
        .SHF_VALID(shf_v), .SHF_READY(shf_r), .SHF_DATA(shf_d));
    //==========================================================
    // tasks
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk) bus <= '{1'b1, 1'b0, a, d};
        @(posedge mclk) bus <= '0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge mclk) bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk) bus <= '0;
        #1 chk("io_rdata", e, rdata);
    endtask : rd
    task automatic stat_read;
        @(posedge mclk) stat_rd <= 1'b1;
        @(posedge mclk) stat_rd <= 1'b0;
        @(negedge mclk);
    endtask : stat_read
    task automatic settle;
        repeat (8) @(negedge mclk);
    endtask : settle
    task automatic stop_test;
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    //==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (adr[i]) rd(adr[i], 8'h00);
        rd(8'h14, 8'h00);
        wr(8'h12, 8'hFF);
        wr(8'h13, 8'hFF);
        rd(8'h12, 8'hFD);
        rd(8'h13, 8'h9D);
        chk("rx_int_en", 2'h3, rie);
        chk("x1_mode", 2'h3, x1);
        chk("rate_mode", 2'h3, rate);
        chk("tx_line_brk", 2'h0, txl);
        for (int i = 2; i < 6; i++) wr(adr[i], 8'h5A + 8'(i));
        for (int i = 2; i < 6; i++) rd(adr[i], 8'h5A + 8'(i));
        // rate off so the counter loads the new constant
        wr(8'h12, 8'h00);
        wr(8'h1A, 8'h03);
        wr(8'h1B, 8'h00);
        wr(8'h12, 8'h08);
        wr(8'h13, 8'h00);
        #1 chk("rx_int_off", 2'h0, rie);
        chk("tx_line", 2'h3, txl);
        for (k = 0; k < 50 && !tick[0]; k++) @(negedge mclk);
        @(negedge mclk);
        for (k = 1; k < 50 && !tick[0]; k++) @(negedge mclk);
        chk("tick_gap", 16'h0004, 16'(k));
        chk("tick1_off", 1'b0, tick[1]);
        cts <= 1'b1;
        settle();
        chk("tx_empty_cts", 1'b0, fl0.tx_empty);
        chk("cts_stat", 1'b1, cts_s);
        @(posedge mclk);
        txd_v <= 2'b01;
        txd_d <= 16'h00A5;
        @(posedge mclk);
        txd_v <= 2'b00;
        @(negedge mclk);
        chk("shf_data0", 9'h1A5, {shf_v[0], shf_d[7:0]});
        @(posedge mclk);
        shf_r <= 2'b01;
        wr(8'h12, 8'h28);
        #1 chk("tx_empty_adv", 1'b1, fl0.tx_empty);
        cts <= 1'b0;
        wr(8'h12, 8'h08);
        car <= 1'b1;
        settle();
        chk("flags_cd", 5'h08, fl0);
        stat_read();
        car <= 1'b0;
        settle();
        chk("flags_held", 5'h08, fl0);
        chk("dcd_first", 1'b1, dcd_s);
        stat_read();
        chk("flags_back", 5'h1F, fl0);
        chk("dcd_second", 1'b0, dcd_s);
        wr(8'h12, 8'h48);
        car <= 1'b1;
        settle();
        chk("rx_full_adv", 1'b1, fl0.rx_full);
        car <= 1'b0;
        settle();
        stat_read();
        stat_read();
        ch1_clear_to_send_in <= 1'b1;
        settle();
        chk("ch1_nosel", 2'h2, {fl1.tx_empty, ch1_clear_to_send_in_s});
        @(posedge mclk) sel1 <= 1'b1;
        settle();
        chk("ch1_sel", 2'h1, {fl1.tx_empty, ch1_clear_to_send_in_s});
        @(posedge mclk);
        rts_wr <= 1'b1;
        rts_d <= 1'b1;
        @(posedge mclk);
        rts_wr <= 1'b0;
        @(negedge mclk);
        chk("rts_out", 1'b1, rts);
        rd(8'h12, 8'h48);
        rd(8'h1A, 8'h03);
        brk <= 1'b1;
        repeat (270) @(negedge mclk);
        rd(8'h12, 8'h4A);
        rd(8'h13, 8'h02);
        brk <= 1'b0;
        @(posedge mclk);
        txd_v <= 2'b10;
        txd_d <= 16'hC300;
        repeat (2) @(posedge mclk);
        txd_v <= 2'b00;
        @(negedge mclk);
        chk("txd_full", 1'b0, txd_r[1]);
        chk("shf_data1", 8'hC3, shf_d[15:8]);
        @(posedge mclk);
        shf_r <= 2'b11;
        n = 0;
        for (k = 0; k < 6; k++) begin
            @(negedge mclk);
            if (shf_v[1] === 1'b1)
                n++;
        end
        chk("drained", 16'h0002, 16'(n));
        stop_test();
    end
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule : test_asx_ext_top
